// File: inc/conv_ctrl_map.svh
// Constants shared by the conversion control and decimation files
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH

// Command opcodes; the lowest bit is ignored
`define OP_MAIN_BEGIN 8'h08
`define OP_MAIN_HALT 8'h0A
`define OP_AUX_BEGIN 8'h0C
`define OP_AUX_HALT 8'h0E
`define OPCODE_EFFECT_EDGE 3'h6

// Toggle positions in the command crossing vector
`define EVT_MAIN_BEGIN 0
`define EVT_MAIN_HALT 1
`define EVT_AUX_BEGIN 2
`define EVT_AUX_HALT 3
`define EVT_COUNT 4

// Mode byte field and main converter timing
`define STYLE_BIT 6
`define STOP_SETUP_CLKS 16
`define MAIN_CONV_DEFAULT 2048

// Auxiliary modulator and decimation
`define MOD_LAST 8'h8F
`define DEC_A_SLOW 10'h200
`define DEC_A_MID 10'h080
`define DEC_A_FAST 10'h040
`define DEC_B_LAST 4'h9
`define DEC_B_DIV 28'h000_000A
`define SHIFT_MID 5'h06
`define SHIFT_FAST 5'h09
`define NORM_SHIFT 5'h04
`define AUX_POS_FULL 29'h007F_FFFF
`define AUX_ACC_W 29
`define AVG_W 28
`define RESULT_W 24

`endif

// File: inc/conv_ctrl_pkg.sv
// Types shared by the conversion control and decimation files
package conv_ctrl_pkg;

	typedef enum logic [1:0] {
		MAIN_IDLE = 2'h1,
		MAIN_CONVERT = 2'h2
	} main_state_t;

	typedef enum logic [1:0] {
		RATE_10SPS = 2'h0,
		RATE_100SPS = 2'h1,
		RATE_400SPS = 2'h2,
		RATE_800SPS = 2'h3
	} aux_rate_t;

endpackage : conv_ctrl_pkg

// File: logic/cmd_link_rx.sv
// Serial command receiver on the link clock, one toggle per recognised opcode
`include "conv_ctrl_map.svh"

module cmd_link_rx (
	input wire logic sclk_i,
	input wire logic select_n_i,
	input wire logic serial_data_i,
	input wire logic reset_n_i,
	output logic main_begin_tgl_o,
	output logic main_halt_tgl_o,
	output logic aux_begin_tgl_o,
	output logic aux_halt_tgl_o
);

	logic [2:0] bit_cnt_r;
	logic [2:0] bit_cnt_nxt;
	logic [5:0] shift_r;
	logic [5:0] shift_nxt;
	logic [`EVT_COUNT-1:0] tgl_r;
	logic [`EVT_COUNT-1:0] tgl_nxt;
	logic [6:0] head;

	function automatic logic head_is(input logic [6:0] h, input logic [7:0] code);
		return h == code[7:1];
	endfunction : head_is

	////////////////////////////////////////////////////////////////////////////
	// Bits are taken on falling edges, MSB first
	always_comb begin
		bit_cnt_nxt = bit_cnt_r + 3'h1;
		shift_nxt = {shift_r[4:0], serial_data_i};
		head = {shift_r, serial_data_i};
		tgl_nxt = tgl_r;
		if (bit_cnt_r == `OPCODE_EFFECT_EDGE) begin
			if (head_is(head, `OP_MAIN_BEGIN)) begin
				tgl_nxt[`EVT_MAIN_BEGIN] = ~tgl_r[`EVT_MAIN_BEGIN];
			end else if (head_is(head, `OP_MAIN_HALT)) begin
				tgl_nxt[`EVT_MAIN_HALT] = ~tgl_r[`EVT_MAIN_HALT];
			end else if (head_is(head, `OP_AUX_BEGIN)) begin
				tgl_nxt[`EVT_AUX_BEGIN] = ~tgl_r[`EVT_AUX_BEGIN];
			end else if (head_is(head, `OP_AUX_HALT)) begin
				tgl_nxt[`EVT_AUX_HALT] = ~tgl_r[`EVT_AUX_HALT];
			end
		end
	end

	// Frame position cleared by deselect, so no edge outside a frame is needed
	always_ff @(negedge sclk_i or posedge select_n_i) begin
		if (select_n_i) begin
			bit_cnt_r <= 3'h0;
			shift_r <= 6'h00;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
		end
	end

	always_ff @(negedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tgl_r <= '0;
		end else begin
			tgl_r <= tgl_nxt;
		end
	end

	assign main_begin_tgl_o = tgl_r[`EVT_MAIN_BEGIN];
	assign main_halt_tgl_o = tgl_r[`EVT_MAIN_HALT];
	assign aux_begin_tgl_o = tgl_r[`EVT_AUX_BEGIN];
	assign aux_halt_tgl_o = tgl_r[`EVT_AUX_HALT];

endmodule : cmd_link_rx

// File: logic/aux_decimator.sv
// Auxiliary sinc3 first stage and ten-sample sinc1 second stage
`include "conv_ctrl_map.svh"

module aux_decimator (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic clear_i,
	input wire logic sample_tick_i,
	input wire logic sample_bit_i,
	input wire logic [1:0] rate_select_i,
	output logic [`RESULT_W-1:0] result_o,
	output logic result_valid_o
);

	typedef logic signed [`AUX_ACC_W-1:0] acc_t;
	typedef logic signed [`AVG_W-1:0] avg_t;

	acc_t integ_r [3];
	acc_t integ_nxt [3];
	acc_t dly_r [3];
	acc_t dly_nxt [3];
	logic [9:0] dec_cnt_r;
	logic [9:0] dec_cnt_nxt;
	avg_t avg_r;
	avg_t avg_nxt;
	logic [3:0] avg_cnt_r;
	logic [3:0] avg_cnt_nxt;
	logic [`RESULT_W-1:0] result_r;
	logic [`RESULT_W-1:0] result_nxt;
	logic valid_r;
	logic valid_nxt;
	conv_ctrl_pkg::aux_rate_t rate;
	acc_t diff;
	acc_t sample;
	logic signed [`RESULT_W-1:0] stage_out;
	avg_t avg_sum;
	avg_t quot;

	function automatic logic [9:0] first_ratio(input conv_ctrl_pkg::aux_rate_t r);
		case (r)
			conv_ctrl_pkg::RATE_400SPS: return `DEC_A_MID;
			conv_ctrl_pkg::RATE_800SPS: return `DEC_A_FAST;
			default: return `DEC_A_SLOW;
		endcase
	endfunction : first_ratio

	// Brings every ratio to the same full scale, clamping the one positive overflow code
	function automatic logic signed [`RESULT_W-1:0] to_result(input acc_t c, input conv_ctrl_pkg::aux_rate_t r);
		acc_t t;
		t = c;
		if (r == conv_ctrl_pkg::RATE_400SPS) begin
			t = c <<< `SHIFT_MID;
		end else if (r == conv_ctrl_pkg::RATE_800SPS) begin
			t = c <<< `SHIFT_FAST;
		end
		t = t >>> `NORM_SHIFT;
		if (t > $signed(`AUX_POS_FULL)) begin
			t = `AUX_POS_FULL;
		end
		return t[`RESULT_W-1:0];
	endfunction : to_result

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		rate = conv_ctrl_pkg::aux_rate_t'(rate_select_i);
		sample = sample_bit_i ? acc_t'(1) : -acc_t'(1);
		integ_nxt = integ_r;
		dly_nxt = dly_r;
		dec_cnt_nxt = dec_cnt_r;
		avg_nxt = avg_r;
		avg_cnt_nxt = avg_cnt_r;
		result_nxt = result_r;
		valid_nxt = 1'b0;
		diff = integ_r[2];
		stage_out = '0;
		avg_sum = '0;
		quot = '0;
		if (clear_i) begin
			integ_nxt = '{default: '0};
			dly_nxt = '{default: '0};
			dec_cnt_nxt = '0;
			avg_nxt = '0;
			avg_cnt_nxt = '0;
		end else if (sample_tick_i) begin
			integ_nxt[0] = integ_r[0] + sample;
			integ_nxt[1] = integ_r[1] + integ_r[0];
			integ_nxt[2] = integ_r[2] + integ_r[1];
			dec_cnt_nxt = dec_cnt_r + 10'h001;
			if (dec_cnt_r >= first_ratio(rate) - 10'h001) begin
				dec_cnt_nxt = '0;
				// Comb reads the third integrator as updated on this tick, so the third output is settled
				diff = integ_nxt[2];
				for (int i = 0; i < 3; i++) begin
					dly_nxt[i] = diff;
					diff = diff - dly_r[i];
				end
				stage_out = to_result(diff, rate);
				avg_sum = avg_r + avg_t'(stage_out);
				if (rate != conv_ctrl_pkg::RATE_10SPS) begin
					result_nxt = stage_out;
					valid_nxt = 1'b1;
					avg_nxt = '0;
					avg_cnt_nxt = '0;
				end else if (avg_cnt_r == `DEC_B_LAST) begin
					quot = avg_sum / $signed(`DEC_B_DIV);
					result_nxt = quot[`RESULT_W-1:0];
					valid_nxt = 1'b1;
					avg_nxt = '0;
					avg_cnt_nxt = '0;
				end else begin
					avg_nxt = avg_sum;
					avg_cnt_nxt = avg_cnt_r + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			integ_r <= '{default: '0};
			dly_r <= '{default: '0};
			dec_cnt_r <= '0;
			avg_r <= '0;
			avg_cnt_r <= '0;
			result_r <= '0;
			valid_r <= 1'b0;
		end else if (clk_en_i) begin
			integ_r <= integ_nxt;
			dly_r <= dly_nxt;
			dec_cnt_r <= dec_cnt_nxt;
			avg_r <= avg_nxt;
			avg_cnt_r <= avg_cnt_nxt;
			result_r <= result_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign result_o = result_r;
	assign result_valid_o = valid_r;

endmodule : aux_decimator

// File: logic/conversion_control.sv
// Main converter sequencing, command crossing and auxiliary decimation top
`include "conv_ctrl_map.svh"

module conversion_control #(
	parameter int unsigned MAIN_CONV_CYCLES = `MAIN_CONV_DEFAULT
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic sclk_i,
	input wire logic select_n_i,
	input wire logic serial_data_i,
	input wire logic start_pin_i,
	input wire logic [7:0] mode_register_zero_i,
	input wire logic [1:0] aux_rate_select_i,
	input wire logic aux_mod_bit_i,
	output logic result_ready_n_o,
	output logic main_busy_o,
	output logic aux_running_o,
	output logic [`RESULT_W-1:0] aux_result_o,
	output logic aux_result_valid_o
);

	localparam int CW = $clog2(MAIN_CONV_CYCLES);
	localparam logic [CW-1:0] CNT_LAST = CW'(MAIN_CONV_CYCLES - 1);
	localparam logic [CW-1:0] CNT_BLIP = CW'(MAIN_CONV_CYCLES - 2);
	localparam logic [CW-1:0] STOP_SETUP = CW'(`STOP_SETUP_CLKS);

	generate
		if (MAIN_CONV_CYCLES < 2 * `STOP_SETUP_CLKS) begin : g_bad_len
			$error("MAIN_CONV_CYCLES too small for the stop set-up window");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Link side: opcode recognition on the serial clock

	logic [`EVT_COUNT-1:0] link_tgl;

	cmd_link_rx u_link (
		.sclk_i(sclk_i),
		.select_n_i(select_n_i),
		.serial_data_i(serial_data_i),
		.reset_n_i(reset_n_i),
		.main_begin_tgl_o(link_tgl[`EVT_MAIN_BEGIN]),
		.main_halt_tgl_o(link_tgl[`EVT_MAIN_HALT]),
		.aux_begin_tgl_o(link_tgl[`EVT_AUX_BEGIN]),
		.aux_halt_tgl_o(link_tgl[`EVT_AUX_HALT])
	);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers: command toggles, start pin, modulator bit

	logic [`EVT_COUNT-1:0] tgl_meta_r;
	logic [`EVT_COUNT-1:0] tgl_sync_r;
	logic [`EVT_COUNT-1:0] tgl_prev_r;
	logic [`EVT_COUNT-1:0] tgl_meta_nxt;
	logic [`EVT_COUNT-1:0] tgl_sync_nxt;
	logic [`EVT_COUNT-1:0] tgl_prev_nxt;
	logic [`EVT_COUNT-1:0] cmd_evt;
	logic start_meta_r;
	logic start_sync_r;
	logic start_prev_r;
	logic start_meta_nxt;
	logic start_sync_nxt;
	logic start_prev_nxt;
	logic mod_meta_r;
	logic mod_sync_r;
	logic mod_meta_nxt;
	logic mod_sync_nxt;

	always_comb begin
		tgl_meta_nxt = link_tgl;
		tgl_sync_nxt = tgl_meta_r;
		tgl_prev_nxt = tgl_sync_r;
		start_meta_nxt = start_pin_i;
		start_sync_nxt = start_meta_r;
		start_prev_nxt = start_sync_r;
		mod_meta_nxt = aux_mod_bit_i;
		mod_sync_nxt = mod_meta_r;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tgl_meta_r <= '0;
			tgl_sync_r <= '0;
			tgl_prev_r <= '0;
			start_meta_r <= 1'b0;
			start_sync_r <= 1'b0;
			start_prev_r <= 1'b0;
			mod_meta_r <= 1'b0;
			mod_sync_r <= 1'b0;
		end else if (clk_en_i) begin
			tgl_meta_r <= tgl_meta_nxt;
			tgl_sync_r <= tgl_sync_nxt;
			tgl_prev_r <= tgl_prev_nxt;
			start_meta_r <= start_meta_nxt;
			start_sync_r <= start_sync_nxt;
			start_prev_r <= start_prev_nxt;
			mod_meta_r <= mod_meta_nxt;
			mod_sync_r <= mod_sync_nxt;
		end
	end

	assign cmd_evt = tgl_sync_r ^ tgl_prev_r;

	////////////////////////////////////////////////////////////////////////////
	// Main converter sequencing

	conv_ctrl_pkg::main_state_t state_r;
	conv_ctrl_pkg::main_state_t state_nxt;
	logic [CW-1:0] conv_cnt_r;
	logic [CW-1:0] conv_cnt_nxt;
	logic ready_n_r;
	logic ready_n_nxt;
	logic busy_r;
	logic busy_nxt;
	logic halt_due_r;
	logic halt_due_nxt;
	logic halt_late_r;
	logic halt_late_nxt;
	logic single_shot;
	logic pin_rise;
	logic pin_fall;
	logic begin_req;
	logic halt_req;
	logic [CW-1:0] remaining;

	always_comb begin
		single_shot = mode_register_zero_i[`STYLE_BIT];
		pin_rise = start_sync_r & ~start_prev_r;
		pin_fall = ~start_sync_r & start_prev_r;
		begin_req = pin_rise | cmd_evt[`EVT_MAIN_BEGIN];
		halt_req = pin_fall | cmd_evt[`EVT_MAIN_HALT];
		remaining = CNT_LAST - conv_cnt_r;
		state_nxt = state_r;
		conv_cnt_nxt = conv_cnt_r;
		ready_n_nxt = ready_n_r;
		halt_due_nxt = halt_due_r;
		halt_late_nxt = halt_late_r;
		if (begin_req) begin
			// Start and restart alike; a pending stop is dropped
			state_nxt = conv_ctrl_pkg::MAIN_CONVERT;
			conv_cnt_nxt = '0;
			ready_n_nxt = 1'b1;
			halt_due_nxt = 1'b0;
			halt_late_nxt = 1'b0;
		end else begin
			case (state_r)
				conv_ctrl_pkg::MAIN_IDLE: begin
					conv_cnt_nxt = '0;
				end
				conv_ctrl_pkg::MAIN_CONVERT: begin
					// Late stops let one more conversion through
					if (halt_req && !single_shot) begin
						if (remaining >= STOP_SETUP) begin
							halt_due_nxt = 1'b1;
						end else begin
							halt_late_nxt = 1'b1;
						end
					end
					if (conv_cnt_r == CNT_LAST) begin
						ready_n_nxt = 1'b0;
						conv_cnt_nxt = '0;
						if (single_shot || halt_due_nxt) begin
							state_nxt = conv_ctrl_pkg::MAIN_IDLE;
							halt_due_nxt = 1'b0;
							halt_late_nxt = 1'b0;
						end else if (halt_late_nxt) begin
							halt_due_nxt = 1'b1;
							halt_late_nxt = 1'b0;
						end
					end else begin
						conv_cnt_nxt = conv_cnt_r + {{(CW - 1){1'b0}}, 1'b1};
						// One-cycle high before each new result keeps a falling edge per result
						if (conv_cnt_r == CNT_BLIP) begin
							ready_n_nxt = 1'b1;
						end
					end
				end
				default: begin
					state_nxt = conv_ctrl_pkg::MAIN_IDLE;
				end
			endcase
		end
		busy_nxt = (state_nxt == conv_ctrl_pkg::MAIN_CONVERT);
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= conv_ctrl_pkg::MAIN_IDLE;
			conv_cnt_r <= '0;
			ready_n_r <= 1'b1;
			busy_r <= 1'b0;
			halt_due_r <= 1'b0;
			halt_late_r <= 1'b0;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			ready_n_r <= ready_n_nxt;
			busy_r <= busy_nxt;
			halt_due_r <= halt_due_nxt;
			halt_late_r <= halt_late_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Auxiliary run control and modulator sample timing

	logic aux_run_r;
	logic aux_run_nxt;
	logic [7:0] mod_cnt_r;
	logic [7:0] mod_cnt_nxt;
	logic mod_tick;
	logic aux_clear;

	always_comb begin
		aux_run_nxt = aux_run_r;
		if (cmd_evt[`EVT_AUX_BEGIN]) begin
			aux_run_nxt = 1'b1;
		end else if (cmd_evt[`EVT_AUX_HALT]) begin
			aux_run_nxt = 1'b0;
		end
		mod_tick = (mod_cnt_r == `MOD_LAST);
		mod_cnt_nxt = mod_tick ? 8'h00 : mod_cnt_r + 8'h01;
		// Restart empties the filter; stopped chain is held clear
		aux_clear = cmd_evt[`EVT_AUX_BEGIN] | cmd_evt[`EVT_AUX_HALT] | ~aux_run_r;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aux_run_r <= 1'b0;
			mod_cnt_r <= 8'h00;
		end else if (clk_en_i) begin
			aux_run_r <= aux_run_nxt;
			mod_cnt_r <= mod_cnt_nxt;
		end
	end

	aux_decimator u_aux (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.clear_i(aux_clear),
		.sample_tick_i(mod_tick),
		.sample_bit_i(mod_sync_r),
		.rate_select_i(aux_rate_select_i),
		.result_o(aux_result_o),
		.result_valid_o(aux_result_valid_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign result_ready_n_o = ready_n_r;
	assign main_busy_o = busy_r;
	assign aux_running_o = aux_run_r;

endmodule : conversion_control

// File: verification/conversion_control_props.sv
// Assertion checker bound to the conversion control top
`include "conv_ctrl_map.svh"

module conversion_control_props #(
	parameter int unsigned MAIN_CONV_CYCLES = 64
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic start_pin_i,
	input wire logic [7:0] mode_register_zero_i,
	input wire logic [1:0] aux_rate_select_i,
	input wire logic result_ready_n_o,
	input wire logic main_busy_o,
	input wire logic aux_running_o,
	input wire logic [`RESULT_W-1:0] aux_result_o,
	input wire logic aux_result_valid_o
);
	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	logic single_shot;
	logic seen_r, seen_nxt;
	logic [19:0] gap_r, gap_nxt, gap_exp;

	assign single_shot = mode_register_zero_i[`STYLE_BIT];

	////////////////////////////////////////////////////////////
	// Cycles between auxiliary results
	always_comb begin
		gap_nxt = aux_result_valid_o ? 20'h0_0001 : gap_r + 20'h0_0001;
		seen_nxt = aux_running_o && (seen_r || aux_result_valid_o);
		case (aux_rate_select_i)
			2'h0: gap_exp = 20'hb_4000;
			2'h1: gap_exp = 20'h1_2000;
			2'h2: gap_exp = 20'h0_4800;
			default: gap_exp = 20'h0_2400;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap_r <= 20'h0_0000;
			seen_r <= 1'b0;
		end else begin
			gap_r <= gap_nxt;
			seen_r <= seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////
	sequence shot_start_s;
		single_shot && $rose(start_pin_i);
	endsequence

	sequence conv_begun_s;
		result_ready_n_o && main_busy_o;
	endsequence

	a_shot_ready_rise: assert property (shot_start_s |-> ##[1:3] conv_begun_s)
		else $error("ready not raised after start");
	a_valid_gap: assert property (aux_result_valid_o && seen_r |-> gap_r == gap_exp)
		else $error("aux result spacing wrong");
	a_valid_pulse: assert property (aux_result_valid_o |=> !aux_result_valid_o)
		else $error("aux valid longer than one cycle");
	a_result_hold: assert property (!aux_result_valid_o |-> $stable(aux_result_o))
		else $error("aux result changed without valid");
	a_valid_running: assert property (aux_result_valid_o |-> aux_running_o)
		else $error("aux result while stopped");
	a_shot_halts: assert property (single_shot && $fell(main_busy_o) |-> $fell(result_ready_n_o))
		else $error("single conversion ended without result");
	a_run_keeps: assert property (!single_shot && start_pin_i && $past(start_pin_i, 4) && main_busy_o |=> main_busy_o)
		else $error("continuous run stopped with pin high");
	a_pin_not_aux: assert property ($changed(start_pin_i) |=> $stable(aux_running_o) [*4])
		else $error("start pin moved aux state");
	a_reset_idle: assert property (disable iff (1'b0) !reset_n_i ##1 !reset_n_i |-> result_ready_n_o && !main_busy_o && !aux_running_o && !aux_result_valid_o)
		else $error("outputs not idle in reset");
endmodule : conversion_control_props

bind conversion_control conversion_control_props #(.MAIN_CONV_CYCLES(MAIN_CONV_CYCLES)) chk (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_pin_i(start_pin_i),
	.mode_register_zero_i(mode_register_zero_i), .aux_rate_select_i(aux_rate_select_i),
	.result_ready_n_o(result_ready_n_o), .main_busy_o(main_busy_o), .aux_running_o(aux_running_o),
	.aux_result_o(aux_result_o), .aux_result_valid_o(aux_result_valid_o)
);

// File: verification/host_link_model.sv
// Host model driving serial opcodes and the start pin
module host_link_model (
	input wire logic sys_clk_i,
	output logic sclk_o,
	output logic select_n_o,
	output logic serial_data_o,
	output logic start_pin_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk_o = 1'b1;
		select_n_o = 1'b1;
		serial_data_o = 1'b0;
		start_pin_o = 1'b0;
	end

	// One byte MSB first; clock stands high outside the frame
	task automatic send_cmd(input logic [7:0] op);
		#1.7;
		select_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			serial_data_o = op[i];
			#6 sclk_o = 1'b0;
			#6 sclk_o = 1'b1;
		end
		#3 select_n_o = 1'b1;
		serial_data_o = ~serial_data_o;
		repeat (2) @(negedge sys_clk_i);
	endtask : send_cmd

	// Each pin level held at least four clocks
	task automatic pin_set(input logic v);
		@(negedge sys_clk_i);
		start_pin_o = v;
		repeat (3) @(negedge sys_clk_i);
	endtask : pin_set
endmodule : host_link_model

// File: verification/conversion_control_tb.sv
// Self-checking bench for the conversion control top
`include "conv_ctrl_map.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module conversion_control_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int CONV_LEN = 64;
	localparam int RDY = 0;
	localparam int BSY = 1;
	localparam int VLD = 2;

	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] mode = 8'h00;
	logic [1:0] rate = 2'h3;
	logic mod_bit = 1'b1;
	logic clk_en = 1'b1;
	logic sclk, select_n, sdata, start_pin, ready_n, busy, aux_run, valid;
	logic [`RESULT_W-1:0] result;
	int err_count = 0;
	int n_compared = 0;

	always #2 sys_clk = ~sys_clk;

	host_link_model host (.sys_clk_i(sys_clk), .sclk_o(sclk), .select_n_o(select_n), .serial_data_o(sdata),
		.start_pin_o(start_pin));

	conversion_control #(.MAIN_CONV_CYCLES(CONV_LEN)) uut (
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .sclk_i(sclk), .select_n_i(select_n),
		.serial_data_i(sdata), .start_pin_i(start_pin), .mode_register_zero_i(mode), .aux_rate_select_i(rate),
		.aux_mod_bit_i(mod_bit), .result_ready_n_o(ready_n), .main_busy_o(busy), .aux_running_o(aux_run),
		.aux_result_o(result), .aux_result_valid_o(valid)
	);

	////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Bounded wait for an output level, counting cycles
	task automatic wait_lvl(input int w, input logic lvl, input int lim, output int n);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				err_count++;
				tally_and_finish();
			end
		end while ((w == RDY ? ready_n : w == BSY ? busy : valid) !== lvl);
	endtask : wait_lvl

	////////////////////////////////////////////////////////////
	task automatic t_single_pin;
		int n;
		mode = 8'hc5;
		host.pin_set(1'b1);
		host.pin_set(1'b0);
		`CHK(ready_n, 1'b1)
		`CHK(busy, 1'b1)
		wait_lvl(RDY, 1'b0, CONV_LEN, n);
		`CHK(busy, 1'b0)
		repeat (2 * CONV_LEN) @(negedge sys_clk);
		`CHK(ready_n, 1'b0)
		`CHK(busy, 1'b0)
	endtask : t_single_pin

	// Enable low freezes a running conversion past its normal end
	task automatic t_clk_en;
		int n;
		mode = 8'hc5;
		host.pin_set(1'b1);
		host.pin_set(1'b0);
		@(negedge sys_clk);
		clk_en = 1'b0;
		repeat (2 * CONV_LEN) @(negedge sys_clk);
		`CHK(busy, 1'b1)
		`CHK(ready_n, 1'b1)
		clk_en = 1'b1;
		wait_lvl(RDY, 1'b0, CONV_LEN, n);
		`CHK(busy, 1'b0)
	endtask : t_clk_en

	// Pin stays low while opcodes are in use
	task automatic t_single_cmd;
		int n;
		host.send_cmd(`OP_MAIN_BEGIN | 8'h01);
		`CHK(ready_n, 1'b1)
		host.send_cmd(`OP_MAIN_HALT);
		`CHK(busy, 1'b1)
		wait_lvl(RDY, 1'b0, CONV_LEN, n);
		`CHK(busy, 1'b0)
	endtask : t_single_cmd

	task automatic t_cont_cmd;
		int n;
		mode = 8'h3a;
		host.send_cmd(`OP_MAIN_BEGIN);
		`CHK(busy, 1'b1)
		wait_lvl(RDY, 1'b0, CONV_LEN + 8, n);
		wait_lvl(RDY, 1'b1, CONV_LEN, n);
		wait_lvl(RDY, 1'b0, 8, n);
		`CHK(busy, 1'b1)
		// Stop sent just after a result, well before the next
		host.send_cmd(`OP_MAIN_HALT | 8'h01);
		wait_lvl(RDY, 1'b1, CONV_LEN, n);
		wait_lvl(RDY, 1'b0, 8, n);
		repeat (8) @(negedge sys_clk);
		`CHK(busy, 1'b0)
		`CHK(ready_n, 1'b0)
		host.send_cmd(`OP_MAIN_BEGIN | 8'h01);
		wait_lvl(RDY, 1'b0, CONV_LEN + 8, n);
		host.send_cmd(`OP_MAIN_HALT);
		host.send_cmd(`OP_MAIN_BEGIN);
		`CHK(ready_n, 1'b1)
		`CHK(busy, 1'b1)
		host.send_cmd(`OP_MAIN_HALT);
		wait_lvl(BSY, 1'b0, 2 * CONV_LEN + 8, n);
		`CHK(ready_n, 1'b0)
	endtask : t_cont_cmd

	task automatic t_cont_pin;
		int n;
		host.pin_set(1'b1);
		`CHK(busy, 1'b1)
		wait_lvl(RDY, 1'b0, CONV_LEN + 8, n);
		host.pin_set(1'b0);
		host.pin_set(1'b1);
		@(negedge sys_clk);
		`CHK(ready_n, 1'b1)
		`CHK(busy, 1'b1)
		host.pin_set(1'b0);
		wait_lvl(BSY, 1'b0, 2 * CONV_LEN + 8, n);
		`CHK(ready_n, 1'b0)
	endtask : t_cont_pin

	task automatic t_aux;
		int n;
		host.send_cmd(`OP_AUX_BEGIN | 8'h01);
		`CHK(aux_run, 1'b1)
		host.pin_set(1'b1);
		host.pin_set(1'b0);
		`CHK(aux_run, 1'b1)
		repeat (4) wait_lvl(VLD, 1'b1, 9500, n);
		`CHK(n, 9216)
		`CHK(result, 24'h7f_ffff)
		`CHK(ready_n, 1'b0)
		`CHK(busy, 1'b0)
		host.send_cmd(`OP_AUX_HALT | 8'h01);
		`CHK(aux_run, 1'b0)
		rate = 2'h2;
		mod_bit = 1'b0;
		host.send_cmd(`OP_AUX_BEGIN);
		repeat (3) wait_lvl(VLD, 1'b1, 18700, n);
		`CHK(n, 18432)
		`CHK(result, 24'h80_0000)
		host.send_cmd(`OP_AUX_HALT);
		`CHK(aux_run, 1'b0)
	endtask : t_aux

	////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge sys_clk);
		reset_n = 1'b1;
		@(negedge sys_clk);
		`CHK(ready_n, 1'b1)
		`CHK(valid, 1'b0)
		t_single_pin();
		t_clk_en();
		t_single_cmd();
		t_cont_cmd();
		t_cont_pin();
		t_aux();
		tally_and_finish();
	end
endmodule : conversion_control_tb
